// ### include/led_ctrl_pkg.sv
// Purpose: shared constants and types for the LED driver control register bank
// Assumes: 8-bit registers reached over a two-wire serial slave port
// Notes: the design logic takes offsets, reset values and field positions from here; the bench repeats some as literals
package led_ctrl_pkg;
	// register offsets
	localparam logic [7:0] OFF_GREEN_CURRENT = 8'h06;
	localparam logic [7:0] OFF_BLUE_CURRENT = 8'h07;
	localparam logic [7:0] OFF_CONFIG = 8'h08;
	localparam logic [7:0] OFF_RED_PC = 8'h09;
	localparam logic [7:0] OFF_GREEN_PC = 8'h0a;
	localparam logic [7:0] OFF_BLUE_PC = 8'h0b;
	localparam logic [7:0] OFF_STATUS = 8'h0c;
	localparam logic [7:0] OFF_SOFT_RESET = 8'h0d;

	// values after reset, the reset key and the read-zero value
	localparam logic [7:0] RST_CURRENT = 8'haf;
	localparam logic [7:0] RST_CONFIG = 8'h00;
	localparam logic [3:0] RST_POINTER = 4'h0;
	localparam logic [2:0] RST_FLAGS = 3'h0;
	localparam logic [7:0] SOFT_RESET_KEY = 8'hff;
	localparam logic [7:0] READ_ZERO = 8'h00;

	// configuration and status field positions
	localparam int CFG_FAST_DIM_BIT = 6;
	localparam int CFG_AUTO_SLEEP_BIT = 5;
	localparam int CFG_PUMP_HI = 4;
	localparam int CFG_PUMP_LO = 3;
	localparam int CFG_RED_ROUTE_BIT = 2;
	localparam int CFG_CLK_HI = 1;
	localparam int CFG_CLK_LO = 0;
	localparam int STATUS_EXT_CLK_BIT = 3;

	// field encodings
	localparam logic [1:0] HOLD_CODE = 2'h0;
	localparam logic [1:0] PUMP_OFF = 2'h0;
	localparam logic [1:0] PUMP_BYPASS = 2'h1;
	localparam logic [1:0] PUMP_GAIN_1P5 = 2'h2;
	localparam logic [1:0] PUMP_AUTO = 2'h3;
	localparam logic [1:0] CLKSRC_EXTERNAL = 2'h0;
	localparam logic [1:0] CLKSRC_INTERNAL = 2'h1;
	localparam logic [1:0] CLKSRC_AUTO = 2'h2;

	// serial slave: upper five address bits, value is arbitrary
	localparam logic [4:0] SLAVE_ADDR_BASE = 5'h1a;
	localparam logic [3:0] BIT_COUNT_IN_LAST = 4'h8;
	localparam logic [3:0] BIT_COUNT_OUT_LAST = 4'h7;

	typedef enum logic [3:0] {
		ST_IDLE = 4'b0000,
		ST_ADDR = 4'b0001,
		ST_ADDR_ACK = 4'b0010,
		ST_REG = 4'b0011,
		ST_REG_ACK = 4'b0100,
		ST_WDATA = 4'b0101,
		ST_WDATA_ACK = 4'b0110,
		ST_RDATA = 4'b0111,
		ST_RDATA_ACK = 4'b1000
	} bus_state_e;
endpackage : led_ctrl_pkg

// ### design/bit_synchroniser.sv
// Purpose: two-flop synchroniser for levels arriving from outside MCLK
// Assumes: inputs are slow levels relative to MCLK
// Notes: the first stage feeds only the second stage
`timescale 1ns/100ps
module bit_synchroniser #(
	parameter int unsigned WIDTH = 1
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] stage1;

	// metastability settles in stage1 before anyone looks
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			stage1 <= '0;
			sync_out <= '0;
		end else begin
			stage1 <= async_in;
			sync_out <= stage1;
		end
	end
endmodule : bit_synchroniser

// ### design/led_driver_control_registers.sv
// Purpose: control register bank of a three-channel LED driver behind a serial slave port
// Assumes: MCLK at 250 MHz; serial and slow clock pins are asynchronous to it
// Notes: sequencer execution_control fields, end events and clock-detect state come from same-clock logic
`timescale 1ns/100ps

// Summary of operation
// - green and blue current reset to 0xaf
// - config bit 6 picks fast dimming clock
// - config bit 5 enables automatic sleep
// - config bits 4:3 select pump gain
// - config bit 2 routes red supply
// - config bits 1:0 pick controller clock source
// - three 4-bit pointers at 0x09..0x0b
// - pointer access only while channel holds
// - pointer writes take effect on slow clock
// - status bit 3 shows external clock use
// - status bits 2:0 are channel flags
// - reading status clears all three flags
// - interrupt pin low-active, released after read
// - writing 0xff to 0x0d resets all
// - reset write byte gets no acknowledge
// - hold finishes instruction, then pointer accessible
module led_driver_control_registers (
	input wire logic MCLK,
	input wire logic ARST_N,
	input wire logic SCL_IN,
	input wire logic SDA_IN,
	output logic SDA_OUT,
	output logic SDA_OE_N,
	input wire logic [1:0] ADDR_SEL,
	input wire logic SLOW_CLOCK_INPUT,
	input wire logic [5:0] EXECUTION_CONTROL,
	input wire logic [2:0] END_IRQ,
	input wire logic EXTERNAL_CLOCK_ACTIVE,
	output logic [7:0] GREEN_CURRENT,
	output logic [7:0] BLUE_CURRENT,
	output logic FAST_DIMMING_CLOCK_SELECT,
	output logic AUTO_SLEEP_ENABLE,
	output logic [1:0] PUMP_GAIN_SELECT,
	output logic RED_SUPPLY_ROUTE,
	output logic [1:0] CLOCK_SOURCE_SELECT,
	output logic [3:0] RED_PROGRAM_POINTER,
	output logic [3:0] GREEN_PROGRAM_POINTER,
	output logic [3:0] BLUE_PROGRAM_POINTER,
	output logic INT_N,
	output logic SOFT_RESET
);
	logic [1:0] pins_s;
	logic slow_s;
	logic [1:0] addr_s;
	logic scl_s, sda_s, scl_d, sda_d, slow_d;
	logic scl_rise, scl_fall, start_cond, stop_cond, slow_tick;

	led_ctrl_pkg::bus_state_e state, next_state;
	logic [3:0] cnt, next_cnt;
	logic [7:0] shift, next_shift;
	logic [7:0] out_byte, next_out_byte;
	logic drive, next_drive;
	logic [7:0] ptr, next_ptr;
	logic reading, next_reading;
	logic wr_pulse, rd_pulse, rst_pulse;
	logic [7:0] read_data;

	logic [7:0] green, next_green, blue, next_blue, config_reg, next_config;
	logic [3:0] pc [3], next_pc [3];
	logic [3:0] committed [3], next_committed [3];
	logic [2:0] pending, next_pending;
	logic [2:0] flags, next_flags;
	logic int_n, next_int_n;
	logic soft_reset, next_soft_reset;
	logic [2:0] hold;

	// serial pins and the slow clock cross into MCLK here
	bit_synchroniser #(.WIDTH(2)) u_pin_sync (
		.clk(MCLK),
		.rst_n(ARST_N),
		.async_in({SCL_IN, SDA_IN}),
		.sync_out(pins_s)
	);
	bit_synchroniser #(.WIDTH(1)) u_slow_sync (
		.clk(MCLK),
		.rst_n(ARST_N),
		.async_in(SLOW_CLOCK_INPUT),
		.sync_out(slow_s)
	);
	bit_synchroniser #(.WIDTH(2)) u_addr_sync (
		.clk(MCLK),
		.rst_n(ARST_N),
		.async_in(ADDR_SEL),
		.sync_out(addr_s)
	);

	assign scl_s = pins_s[1];
	assign sda_s = pins_s[0];

	// previous values for edge detection
	always_ff @(posedge MCLK or negedge ARST_N) begin
		if (!ARST_N) begin
			scl_d <= 1'b0;
			sda_d <= 1'b0;
			slow_d <= 1'b0;
		end else begin
			scl_d <= scl_s;
			sda_d <= sda_s;
			slow_d <= slow_s;
		end
	end

	assign scl_rise = scl_s & ~scl_d;
	assign scl_fall = ~scl_s & scl_d;
	assign start_cond = scl_s & scl_d & sda_d & ~sda_s;
	assign stop_cond = scl_s & scl_d & ~sda_d & sda_s;
	assign slow_tick = slow_s & ~slow_d;

	// hold decode per channel, index 2 red, 1 green, 0 blue
	always_comb begin
		for (int j = 0; j < 3; j++) begin
			hold[j] = (EXECUTION_CONTROL[2*j +: 2] == led_ctrl_pkg::HOLD_CODE);
		end
	end

	// read multiplexer; unmapped offsets and the reset register read zero
	always_comb begin
		read_data = led_ctrl_pkg::READ_ZERO;
		if (ptr == led_ctrl_pkg::OFF_GREEN_CURRENT) begin
			read_data = green;
		end else if (ptr == led_ctrl_pkg::OFF_BLUE_CURRENT) begin
			read_data = blue;
		end else if (ptr == led_ctrl_pkg::OFF_CONFIG) begin
			read_data = {1'b0, config_reg[6:0]};
		end else if (ptr == led_ctrl_pkg::OFF_RED_PC) begin
			read_data = hold[2] ? {4'h0, pc[2]} : led_ctrl_pkg::READ_ZERO;
		end else if (ptr == led_ctrl_pkg::OFF_GREEN_PC) begin
			read_data = hold[1] ? {4'h0, pc[1]} : led_ctrl_pkg::READ_ZERO;
		end else if (ptr == led_ctrl_pkg::OFF_BLUE_PC) begin
			read_data = hold[0] ? {4'h0, pc[0]} : led_ctrl_pkg::READ_ZERO;
		end else if (ptr == led_ctrl_pkg::OFF_STATUS) begin
			read_data = {4'h0, EXTERNAL_CLOCK_ACTIVE, flags};
		end else if (ptr == led_ctrl_pkg::OFF_SOFT_RESET) begin
			read_data = led_ctrl_pkg::READ_ZERO;
		end
	end

	// serial slave: sample on SCL rise, change SDA on SCL fall
	always_comb begin
		next_state = state;
		next_cnt = cnt;
		next_shift = shift;
		next_out_byte = out_byte;
		next_drive = drive;
		next_ptr = ptr;
		next_reading = reading;
		wr_pulse = 1'b0;
		rd_pulse = 1'b0;
		rst_pulse = 1'b0;
		if (start_cond) begin
			next_state = led_ctrl_pkg::ST_ADDR;
			next_cnt = 4'h0;
			next_drive = 1'b0;
		end else if (stop_cond) begin
			next_state = led_ctrl_pkg::ST_IDLE;
			next_drive = 1'b0;
		end else if (scl_rise) begin
			case (state)
				led_ctrl_pkg::ST_ADDR, led_ctrl_pkg::ST_REG, led_ctrl_pkg::ST_WDATA: begin
					next_shift = {shift[6:0], sda_s};
					next_cnt = cnt + 4'h1;
				end
				led_ctrl_pkg::ST_RDATA_ACK: begin
					// a not-acknowledge ends the read burst
					if (sda_s) begin
						next_state = led_ctrl_pkg::ST_IDLE;
					end
				end
				default: begin
				end
			endcase
		end else if (scl_fall) begin
			case (state)
				led_ctrl_pkg::ST_ADDR: begin
					if (cnt == led_ctrl_pkg::BIT_COUNT_IN_LAST) begin
						if (shift[7:1] == {led_ctrl_pkg::SLAVE_ADDR_BASE, addr_s}) begin
							next_state = led_ctrl_pkg::ST_ADDR_ACK;
							next_drive = 1'b1;
							next_reading = shift[0];
						end else begin
							next_state = led_ctrl_pkg::ST_IDLE;
						end
					end
				end
				led_ctrl_pkg::ST_ADDR_ACK: begin
					next_cnt = 4'h0;
					if (reading) begin
						next_state = led_ctrl_pkg::ST_RDATA;
						rd_pulse = 1'b1;
						next_out_byte = read_data;
						next_drive = ~read_data[7];
						next_ptr = ptr + 8'h01;
					end else begin
						next_state = led_ctrl_pkg::ST_REG;
						next_drive = 1'b0;
					end
				end
				led_ctrl_pkg::ST_REG: begin
					if (cnt == led_ctrl_pkg::BIT_COUNT_IN_LAST) begin
						next_ptr = shift;
						next_state = led_ctrl_pkg::ST_REG_ACK;
						next_drive = 1'b1;
					end
				end
				led_ctrl_pkg::ST_WDATA: begin
					if (cnt == led_ctrl_pkg::BIT_COUNT_IN_LAST) begin
						if (ptr == led_ctrl_pkg::OFF_SOFT_RESET && shift == led_ctrl_pkg::SOFT_RESET_KEY) begin
							// no acknowledge: the bus returns to idle
							rst_pulse = 1'b1;
							next_state = led_ctrl_pkg::ST_IDLE;
							next_drive = 1'b0;
						end else begin
							wr_pulse = 1'b1;
							next_ptr = ptr + 8'h01;
							next_state = led_ctrl_pkg::ST_WDATA_ACK;
							next_drive = 1'b1;
						end
					end
				end
				led_ctrl_pkg::ST_REG_ACK, led_ctrl_pkg::ST_WDATA_ACK: begin
					next_drive = 1'b0;
					next_cnt = 4'h0;
					next_state = led_ctrl_pkg::ST_WDATA;
				end
				led_ctrl_pkg::ST_RDATA: begin
					if (cnt == led_ctrl_pkg::BIT_COUNT_OUT_LAST) begin
						next_drive = 1'b0;
						next_state = led_ctrl_pkg::ST_RDATA_ACK;
					end else begin
						next_out_byte = {out_byte[6:0], 1'b0};
						next_drive = ~out_byte[6];
						next_cnt = cnt + 4'h1;
					end
				end
				led_ctrl_pkg::ST_RDATA_ACK: begin
					next_state = led_ctrl_pkg::ST_RDATA;
					next_cnt = 4'h0;
					rd_pulse = 1'b1;
					next_out_byte = read_data;
					next_drive = ~read_data[7];
					next_ptr = ptr + 8'h01;
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge MCLK or negedge ARST_N) begin
		if (!ARST_N) begin
			state <= led_ctrl_pkg::ST_IDLE;
			cnt <= 4'h0;
			shift <= 8'h00;
			out_byte <= 8'h00;
			drive <= 1'b0;
			ptr <= 8'h00;
			reading <= 1'b0;
		end else begin
			state <= next_state;
			cnt <= next_cnt;
			shift <= next_shift;
			out_byte <= next_out_byte;
			drive <= next_drive;
			ptr <= next_ptr;
			reading <= next_reading;
		end
	end

	// register file; a set of a flag wins over the read clear
	always_comb begin
		next_green = green;
		next_blue = blue;
		next_config = config_reg;
		next_pending = pending;
		next_soft_reset = rst_pulse;
		for (int j = 0; j < 3; j++) begin
			next_pc[j] = pc[j];
			next_committed[j] = committed[j];
			if (slow_tick && pending[j]) begin
				next_committed[j] = pc[j];
				next_pending[j] = 1'b0;
			end
		end
		next_flags = flags;
		if (rd_pulse && ptr == led_ctrl_pkg::OFF_STATUS) begin
			next_flags = led_ctrl_pkg::RST_FLAGS;
		end
		next_flags = next_flags | END_IRQ;
		if (wr_pulse) begin
			if (ptr == led_ctrl_pkg::OFF_GREEN_CURRENT) begin
				next_green = shift;
			end else if (ptr == led_ctrl_pkg::OFF_BLUE_CURRENT) begin
				next_blue = shift;
			end else if (ptr == led_ctrl_pkg::OFF_CONFIG) begin
				next_config = {1'b0, shift[6:0]};
			end else if (ptr >= led_ctrl_pkg::OFF_RED_PC && ptr <= led_ctrl_pkg::OFF_BLUE_PC) begin
				for (int j = 0; j < 3; j++) begin
					// pointer write refused unless the channel holds; host spacing covers the crossing
					if (ptr == led_ctrl_pkg::OFF_BLUE_PC - 8'(j) && hold[j]) begin
						next_pc[j] = shift[3:0];
						next_pending[j] = 1'b1;
					end
				end
			end
			// writes to the reset register other than the key fall through here unused
		end
		if (rst_pulse) begin
			next_green = led_ctrl_pkg::RST_CURRENT;
			next_blue = led_ctrl_pkg::RST_CURRENT;
			next_config = led_ctrl_pkg::RST_CONFIG;
			next_pending = 3'h0;
			next_flags = led_ctrl_pkg::RST_FLAGS;
			for (int j = 0; j < 3; j++) begin
				next_pc[j] = led_ctrl_pkg::RST_POINTER;
				next_committed[j] = led_ctrl_pkg::RST_POINTER;
			end
		end
		next_int_n = ~|next_flags;
	end

	always_ff @(posedge MCLK or negedge ARST_N) begin
		if (!ARST_N) begin
			green <= led_ctrl_pkg::RST_CURRENT;
			blue <= led_ctrl_pkg::RST_CURRENT;
			config_reg <= led_ctrl_pkg::RST_CONFIG;
			pending <= 3'h0;
			flags <= led_ctrl_pkg::RST_FLAGS;
			int_n <= 1'b1;
			soft_reset <= 1'b0;
			for (int j = 0; j < 3; j++) begin
				pc[j] <= led_ctrl_pkg::RST_POINTER;
				committed[j] <= led_ctrl_pkg::RST_POINTER;
			end
		end else begin
			green <= next_green;
			blue <= next_blue;
			config_reg <= next_config;
			pending <= next_pending;
			flags <= next_flags;
			int_n <= next_int_n;
			soft_reset <= next_soft_reset;
			for (int j = 0; j < 3; j++) begin
				pc[j] <= next_pc[j];
				committed[j] <= next_committed[j];
			end
		end
	end

	// outputs; open-drain SDA only ever pulls low
	assign SDA_OUT = 1'b0;
	assign SDA_OE_N = ~drive;
	assign GREEN_CURRENT = green;
	assign BLUE_CURRENT = blue;
	assign FAST_DIMMING_CLOCK_SELECT = config_reg[led_ctrl_pkg::CFG_FAST_DIM_BIT];
	assign AUTO_SLEEP_ENABLE = config_reg[led_ctrl_pkg::CFG_AUTO_SLEEP_BIT];
	assign PUMP_GAIN_SELECT = config_reg[led_ctrl_pkg::CFG_PUMP_HI:led_ctrl_pkg::CFG_PUMP_LO];
	assign RED_SUPPLY_ROUTE = config_reg[led_ctrl_pkg::CFG_RED_ROUTE_BIT];
	assign CLOCK_SOURCE_SELECT = config_reg[led_ctrl_pkg::CFG_CLK_HI:led_ctrl_pkg::CFG_CLK_LO];
	assign RED_PROGRAM_POINTER = committed[2];
	assign GREEN_PROGRAM_POINTER = committed[1];
	assign BLUE_PROGRAM_POINTER = committed[0];
	assign INT_N = int_n;
	assign SOFT_RESET = soft_reset;

	// checks
	sequence key_byte_done;
		state == led_ctrl_pkg::ST_WDATA && scl_fall && !start_cond && !stop_cond
			&& cnt == led_ctrl_pkg::BIT_COUNT_IN_LAST && ptr == led_ctrl_pkg::OFF_SOFT_RESET
			&& shift == led_ctrl_pkg::SOFT_RESET_KEY;
	endsequence
	sequence reset_applied;
		SOFT_RESET && SDA_OE_N ##1 GREEN_CURRENT == led_ctrl_pkg::RST_CURRENT
			&& BLUE_CURRENT == led_ctrl_pkg::RST_CURRENT && config_reg == led_ctrl_pkg::RST_CONFIG;
	endsequence

	a_reset_current_value: assert property (@(posedge MCLK) $rose(ARST_N) |->
		GREEN_CURRENT == 8'haf && BLUE_CURRENT == 8'haf)
		else $error("current settings not at reset value");
	a_soft_reset_nack: assert property (@(posedge MCLK) disable iff (!ARST_N)
		key_byte_done |=> reset_applied)
		else $error("reset key acknowledged or not applied");
	a_config_fields: assert property (@(posedge MCLK) disable iff (!ARST_N)
		wr_pulse && ptr == led_ctrl_pkg::OFF_CONFIG |=> PUMP_GAIN_SELECT == $past(shift[4:3])
			&& FAST_DIMMING_CLOCK_SELECT == $past(shift[6]) && CLOCK_SOURCE_SELECT == $past(shift[1:0]))
		else $error("configuration field not written");
	a_pointer_gate: assert property (@(posedge MCLK) disable iff (!ARST_N)
		wr_pulse && ptr == led_ctrl_pkg::OFF_BLUE_PC && !hold[0] && !rst_pulse |=> $stable(pc[0]))
		else $error("pointer written outside hold");
	a_pointer_commit: assert property (@(posedge MCLK) disable iff (!ARST_N)
		pending[2] && slow_tick && !rst_pulse && !wr_pulse |=> RED_PROGRAM_POINTER == $past(pc[2]) && !pending[2])
		else $error("pointer not transferred on slow clock");
	a_pointer_waits: assert property (@(posedge MCLK) disable iff (!ARST_N)
		!slow_tick && !rst_pulse |=> $stable(RED_PROGRAM_POINTER))
		else $error("pointer changed without slow clock edge");
	a_flag_raise: assert property (@(posedge MCLK) disable iff (!ARST_N)
		END_IRQ[2] |=> flags[2] && !INT_N)
		else $error("end event did not raise flag and pin");
	a_status_clear: assert property (@(posedge MCLK) disable iff (!ARST_N)
		rd_pulse && ptr == led_ctrl_pkg::OFF_STATUS && END_IRQ == 3'h0 |=> flags == 3'h0 && INT_N)
		else $error("status read did not clear flags");
	a_pin_level: assert property (@(posedge MCLK) disable iff (!ARST_N)
		INT_N == (flags == 3'h0))
		else $error("interrupt pin disagrees with flags");
	a_reset_ignored: assert property (@(posedge MCLK) disable iff (!ARST_N)
		wr_pulse && ptr == led_ctrl_pkg::OFF_SOFT_RESET |=> $stable(config_reg) && !SOFT_RESET)
		else $error("non-key reset write had an effect");
endmodule : led_driver_control_registers

// ### verification/serial_host_model.sv
// Purpose: host side of the two-wire register bus for the LED driver bench
// Assumes: open-drain data line with a pull-up; the host alone drives the clock
// Notes: each phase lasts HALF clocks, never below the eight the slave needs
`timescale 1ns/100ps
module serial_host_model #(
	parameter int HALF = 8
) (
	input wire logic clk,
	input wire logic sda_line,
	output logic scl,
	output logic sda_drv
);
	// bus idles released, both lines high
	initial begin
		scl = 1'b1;
		sda_drv = 1'b1;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask : tick

	// one clock pulse; data moves mid-low so it never races the falling edge
	task automatic pulse(input logic d, output logic seen);
		tick(HALF / 2);
		sda_drv <= d;
		tick(HALF / 2);
		scl <= 1'b1;
		tick(HALF / 2);
		seen = sda_line;
		tick(HALF / 2);
		scl <= 1'b0;
	endtask : pulse

	// also serves as repeated start from a low clock
	task automatic start_cond();
		tick(HALF / 2);
		sda_drv <= 1'b1;
		tick(HALF / 2);
		scl <= 1'b1;
		tick(HALF);
		sda_drv <= 1'b0;
		tick(HALF);
		scl <= 1'b0;
	endtask : start_cond

	task automatic stop_cond();
		tick(HALF / 2);
		sda_drv <= 1'b0;
		tick(HALF / 2);
		scl <= 1'b1;
		tick(HALF);
		sda_drv <= 1'b1;
		tick(HALF);
	endtask : stop_cond

	task automatic send_byte(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) pulse(b[i], s);
		pulse(1'b1, s);
		ack = ~s;
	endtask : send_byte

	task automatic recv_byte(input logic last, output logic [7:0] b);
		logic s;
		for (int i = 7; i >= 0; i--) pulse(1'b1, b[i]);
		pulse(last, s);
	endtask : recv_byte

	// a missing data ack is handed back, never treated as a fault
	task automatic write_reg(input logic [6:0] dev, input logic [7:0] a, input logic [7:0] d,
		output logic [2:0] acks);
		start_cond();
		send_byte({dev, 1'b0}, acks[2]);
		send_byte(a, acks[1]);
		send_byte(d, acks[0]);
		stop_cond();
	endtask : write_reg

	task automatic read_reg(input logic [6:0] dev, input logic [7:0] a, output logic [7:0] d,
		output logic ack);
		logic x;
		start_cond();
		send_byte({dev, 1'b0}, ack);
		send_byte(a, x);
		start_cond();
		send_byte({dev, 1'b1}, x);
		recv_byte(1'b1, d);
		stop_cond();
	endtask : read_reg
endmodule : serial_host_model

// ### verification/led_driver_control_registers_test.sv
// Purpose: self-checking bench for the LED driver control register bank
// Assumes: host model speaks the bus; sequencer inputs are driven here
// Notes: expectations come from an integer register model in this file
`timescale 1ns/100ps
module led_driver_control_registers_test;
	logic MCLK = 1'b0;
	logic ARST_N = 1'b0;
	logic scl, sda_drv, sda_line, sda_out, sda_oe_n, ack;
	logic [1:0] addr_sel = 2'h0;
	logic slow_clk = 1'b0;
	logic [5:0] run_ctl = 6'h00;
	logic [2:0] end_irq = 3'h0;
	logic ext_clk = 1'b0;
	logic [7:0] green_cur, blue_cur, rd, v;
	logic fast_dim, auto_sleep, red_route, int_n, soft_rst;
	logic [1:0] pump_sel, clk_sel;
	logic [3:0] red_ptr, green_ptr, blue_ptr, p;
	logic [2:0] acks;
	logic [6:0] dev;
	logic [2:0] flags = 3'h0;
	int failures = 0;
	int n_checks = 0;
	int seed = 90;
	int soft_pulses = 0;
	int model_reg[int];

	always #2 MCLK = ~MCLK;
	// open drain: either party pulling low wins over the pull-up
	assign sda_line = sda_drv & (sda_oe_n ? 1'b1 : sda_out);
	// count soft reset pulses
	always @(posedge MCLK) if (soft_rst === 1'b1) soft_pulses++;

	serial_host_model u_host (.clk(MCLK), .sda_line(sda_line), .scl(scl), .sda_drv(sda_drv));

	led_driver_control_registers u_dut (.MCLK(MCLK), .ARST_N(ARST_N), .SCL_IN(scl), .SDA_IN(sda_line),
		.SDA_OUT(sda_out), .SDA_OE_N(sda_oe_n), .ADDR_SEL(addr_sel), .SLOW_CLOCK_INPUT(slow_clk),
		.EXECUTION_CONTROL(run_ctl), .END_IRQ(end_irq), .EXTERNAL_CLOCK_ACTIVE(ext_clk),
		.GREEN_CURRENT(green_cur), .BLUE_CURRENT(blue_cur), .FAST_DIMMING_CLOCK_SELECT(fast_dim),
		.AUTO_SLEEP_ENABLE(auto_sleep), .PUMP_GAIN_SELECT(pump_sel), .RED_SUPPLY_ROUTE(red_route),
		.CLOCK_SOURCE_SELECT(clk_sel), .RED_PROGRAM_POINTER(red_ptr), .GREEN_PROGRAM_POINTER(green_ptr),
		.BLUE_PROGRAM_POINTER(blue_ptr), .INT_N(int_n), .SOFT_RESET(soft_rst));

	task automatic chk_val(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk_val

	task automatic chk_bit(input string what, input logic exp, input logic got);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %s expected %b seen %b", what, exp, got);
		end
	endtask : chk_bit

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : tally_and_finish

	// model: reset image, pointer places keyed to their channel's execution_control field
	task automatic model_reset();
		model_reg.delete();
		model_reg[6] = 8'haf;
		model_reg[7] = 8'haf;
		for (int a = 8; a <= 11; a++) model_reg[a] = 8'h00;
		flags = 3'h0;
	endtask : model_reset

	function automatic logic hold(input int a);
		return run_ctl[(11 - a) * 2 +: 2] == 2'h0;
	endfunction : hold

	function automatic logic [7:0] model_read(input int a);
		if (a == 12) return {4'h0, ext_clk, flags};
		if (a >= 9 && a <= 11 && !hold(a)) return 8'h00;
		if (!model_reg.exists(a)) return 8'h00;
		return 8'(model_reg[a]);
	endfunction : model_read

	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic data_ack);
		u_host.write_reg(dev, a, d, acks);
		chk_bit("address ack", 1'b1, acks[2]);
		chk_bit("offset ack", 1'b1, acks[1]);
		chk_bit("data ack", data_ack, acks[0]);
		if (a == 8'h06 || a == 8'h07) model_reg[a] = d;
		if (a == 8'h08) model_reg[a] = d & 8'h7f;
		if (a >= 8'h09 && a <= 8'h0b && hold(a)) model_reg[a] = d & 8'h0f;
	endtask : wr

	task automatic rd_chk(input logic [7:0] a);
		u_host.read_reg(dev, a, rd, ack);
		chk_bit("read address ack", 1'b1, ack);
		chk_val("register read", model_read(a), rd);
		if (a == 8'h0c) flags = 3'h0;
	endtask : rd_chk

	task automatic check_outputs();
		logic [7:0] c;
		c = 8'(model_reg[8]);
		chk_val("green current", 8'(model_reg[6]), green_cur);
		chk_val("blue current", 8'(model_reg[7]), blue_cur);
		chk_bit("fast dimming", c[6], fast_dim);
		chk_bit("auto sleep", c[5], auto_sleep);
		chk_val("pump gain", {6'h0, c[4:3]}, {6'h0, pump_sel});
		chk_bit("red route", c[2], red_route);
		chk_val("clock source", {6'h0, c[1:0]}, {6'h0, clk_sel});
	endtask : check_outputs

	// slow clock stands still except for a single wide pulse
	task automatic slow_pulse();
		slow_clk <= 1'b1;
		repeat (8) @(posedge MCLK);
		slow_clk <= 1'b0;
		repeat (8) @(posedge MCLK);
	endtask : slow_pulse

	task automatic raise_irq(input logic [2:0] which);
		@(posedge MCLK);
		end_irq <= which;
		@(posedge MCLK);
		end_irq <= 3'h0;
		flags = flags | which;
		repeat (4) @(posedge MCLK);
		chk_bit("irq pin low", 1'b0, int_n);
	endtask : raise_irq

	// watchdog sized well above the pointer spacing wait plus all transfers
	initial begin
		repeat (95000) @(posedge MCLK);
		failures++;
		tally_and_finish();
	end

	initial begin : main
		addr_sel = 2'($random(seed));
		dev = {led_ctrl_pkg::SLAVE_ADDR_BASE, addr_sel};
		model_reset();
		repeat (2) @(posedge MCLK);
		ARST_N <= 1'b1;
		repeat (6) @(posedge MCLK);
		check_outputs();
		chk_bit("irq pin idle", 1'b1, int_n);
		for (int a = 6; a <= 13; a++) rd_chk(8'(a));
		wr(8'h00, 8'h5a, 1'b1);
		rd_chk(8'h00);
		u_host.write_reg(dev ^ 7'h10, 8'h06, 8'h12, acks);
		chk_bit("foreign address ack", 1'b0, acks[2]);
		// every pump and clock code, with boundary and random codes around them
		for (int i = 0; i < 4; i++) begin
			v = (i == 0) ? 8'h00 : (i == 3) ? 8'hff : 8'($random(seed));
			wr(8'h06, v, 1'b1);
			wr(8'h07, 8'($random(seed)), 1'b1);
			v = (8'($random(seed)) & 8'he4) | 8'(i << 3) | 8'(i);
			wr(8'h08, v, 1'b1);
			check_outputs();
			rd_chk(8'h08);
			rd_chk(8'h06);
		end
		// red holds, green runs, blue executes once
		run_ctl <= 6'h0b;
		p = 4'($random(seed)) | 4'h1;
		wr(8'h09, {4'h0, p}, 1'b1);
		repeat (4) @(posedge MCLK);
		chk_val("pointer before slow edge", 8'h00, {4'h0, red_ptr});
		slow_pulse();
		chk_val("red pointer", {4'h0, p}, {4'h0, red_ptr});
		rd_chk(8'h09);
		rd_chk(8'h0a);
		repeat (38400) @(posedge MCLK);
		wr(8'h0b, 8'h07, 1'b1);
		slow_pulse();
		chk_val("blue pointer", 8'h00, {4'h0, blue_ptr});
		chk_val("green pointer", 8'h00, {4'h0, green_ptr});
		// flags from two channels, then one, with the clock state bit set
		ext_clk <= 1'b1;
		raise_irq(3'b101);
		rd_chk(8'h0c);
		repeat (4) @(posedge MCLK);
		chk_bit("irq pin released", 1'b1, int_n);
		raise_irq(3'b010);
		rd_chk(8'h0c);
		rd_chk(8'h0c);
		// wrong key leaves all alone; the key itself resets everything
		wr(8'h0d, 8'h55, 1'b1);
		check_outputs();
		chk_val("soft reset pulses", 8'h00, 8'(soft_pulses));
		raise_irq(3'b001);
		wr(8'h0d, 8'hff, 1'b0);
		model_reset();
		repeat (4) @(posedge MCLK);
		chk_val("soft reset pulses", 8'h01, 8'(soft_pulses));
		check_outputs();
		chk_val("red pointer", 8'h00, {4'h0, red_ptr});
		chk_bit("irq pin after reset", 1'b1, int_n);
		rd_chk(8'h0c);
		rd_chk(8'h06);
		tally_and_finish();
	end
endmodule : led_driver_control_registers_test
